// ==== design/pierr_regs.vh ====
// Purpose: constants for the per-port internal error reporter
// Assumes: 64-bit source vector split over a pair of 32-bit words
// Notes: source bit positions are a local assignment
`ifndef PIERR_REGS_VH
`define PIERR_REGS_VH
`define PIERR_NSRC            64
`define PIERR_NFN             3
`define PIERR_FN_BRIDGE       0
`define PIERR_FN_NT           1
`define PIERR_FN_DMA          2
// source bit positions in the status pair
`define PIERR_SRC_TO_POSTED   0
`define PIERR_SRC_TO_NONPOST  1
`define PIERR_SRC_TO_CPL      2
`define PIERR_SRC_TO_INSERTED 3
`define PIERR_SRC_ECC_IFB_CTL 4
`define PIERR_SRC_ECC_IFB_DAT 5
`define PIERR_SRC_ECC_EFB_CTL 6
`define PIERR_SRC_ECC_EFB_DAT 7
`define PIERR_SRC_ECC_REPLAY  8
`define PIERR_SRC_PARITY      9
`define PIERR_SRC_DMA_TO_P    10
`define PIERR_SRC_DMA_TO_NP   11
`define PIERR_SRC_DMA_TO_CPL  12
`define PIERR_SRC_DMA_IFB_CTL 13
`define PIERR_SRC_DMA_IFB_DAT 14
`define PIERR_SRC_DMA_EFB_CTL 15
`define PIERR_SRC_DMA_EFB_DAT 16
`define PIERR_SRC_DMA_PARITY  17
`define PIERR_SRC_RELAY_LO    32
// dma mask is the bridge and nt default mask; relay mask strips relayed sources from the nt and dma inputs
`define PIERR_DMA_SRC_MASK    64'h000000000003FC00
`define PIERR_RELAY_SRC_MASK  64'hFFFFFFFF00000000
`define PIERR_SEV_RESET       64'h0000000000000000
`define PIERR_HDR_ONES        128'hFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFFF
// queue age limit before a packet is dropped
`define PIERR_TIMEOUT_S       64
`define PIERR_CLK_HZ          20000000
`endif

// ==== design/pierr_fn_aer.v ====
// Purpose: advanced error status slice of one port function
// Assumes: clk at 20 MHz, resetn asynchronous active low
// Notes: one instance per bridge, nontransparent and dma function
`timescale 1ns/1ps
`default_nettype none
module pierr_fn_aer #(
	parameter NSRC = 64,
	parameter [NSRC-1:0] MASK_RESET = {NSRC{1'b0}}
) (
	input  wire            clk,
	input  wire            resetn,
	input  wire            present,          // function exists in this port
	input  wire            report_enable,    // port-wide reporting enable
	input  wire [NSRC-1:0] detect,           // detected events this cycle
	input  wire [NSRC-1:0] severity,         // 1 = uncorrectable
	input  wire            mask_wr,          // write the function mask pair
	input  wire [NSRC-1:0] mask_wdata,       // mask data, 1 = hidden
	input  wire            clr_uncorr,       // write-one-clear of uncorrectable flag
	input  wire            clr_corr,         // write-one-clear of correctable flag
	input  wire            amask_wr,         // write of advanced mask/severity fields
	input  wire            amask_uncorr_in,  // new uncorrectable mask field
	input  wire            asev_uncorr_in,   // new uncorrectable severity field
	input  wire            amask_corr_in,    // new correctable mask field
	input  wire            ahlo_mask_in,     // new header log overflow mask field
	output reg  [NSRC-1:0] fn_err_mask,      // function mask pair
	output reg             uncorr_internal_flag,
	output reg             corr_internal_flag,
	output reg             adv_uncorr_mask,
	output reg             adv_uncorr_severity,
	output reg             adv_corr_mask,
	output reg             header_log_overflow_mask,
	output reg             uncorr_msg,       // one-cycle message to root complex
	output reg             corr_msg,         // one-cycle message to root complex
	output reg             hdr_log_valid     // header log holds all ones
);
	wire [NSRC-1:0] live   = detect & ~fn_err_mask;   // unmasked events
	wire            hit_u  = |(live & severity);      // uncorrectable events
	wire            hit_c  = |(live & ~severity);     // correctable events
	wire            take_u = present & report_enable & hit_u;
	wire            take_c = present & report_enable & hit_c;

	// mask pair always writable; advanced fields frozen while reporting is off
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fn_err_mask              <= MASK_RESET;
			adv_uncorr_mask          <= 1'b0;
			adv_uncorr_severity      <= 1'b0;
			adv_corr_mask            <= 1'b0;
			header_log_overflow_mask <= 1'b0;
		end else begin
			if (mask_wr) begin
				fn_err_mask <= mask_wdata;
			end
			if (amask_wr && report_enable) begin
				adv_uncorr_mask          <= amask_uncorr_in;
				adv_uncorr_severity      <= asev_uncorr_in;
				adv_corr_mask            <= amask_corr_in;
				header_log_overflow_mask <= ahlo_mask_in;
			end
		end
	end

	// sticky flags, set beats clear, messages only on first set
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uncorr_internal_flag <= 1'b0;
			corr_internal_flag   <= 1'b0;
			uncorr_msg           <= 1'b0;
			corr_msg             <= 1'b0;
			hdr_log_valid        <= 1'b0;
		end else begin
			// masked events never reach the flags
			if (take_u) begin
				uncorr_internal_flag <= 1'b1;
			end else if (clr_uncorr && report_enable) begin
				uncorr_internal_flag <= 1'b0;
			end
			if (take_c) begin
				corr_internal_flag <= 1'b1;
			end else if (clr_corr && report_enable) begin
				corr_internal_flag <= 1'b0;
			end
			// suppress while flag already set
			uncorr_msg <= take_u & ~uncorr_internal_flag & ~adv_uncorr_mask;
			corr_msg   <= take_c & ~corr_internal_flag & ~adv_corr_mask;
			if (take_u) begin
				hdr_log_valid <= 1'b1;
			end else if (clr_uncorr && report_enable) begin
				hdr_log_valid <= 1'b0;
			end
		end
	end
endmodule // pierr_fn_aer
`default_nettype wire

// ==== design/pierr_port.v ====
// Purpose: per-port internal error logging, filtering and reporting
// Assumes: single clock clk at 20 MHz, resetn asynchronous active low
// Notes: error inputs are same-domain pulses; no register bus, plain ports
//
// Contract
// - timeouts, ecc, parity count as internal errors
// - report through detecting port's own functions
// - one port enable gates all function reporting
// - advanced fields read-only while reporting disabled
// - uncorrectable report logs all-ones header
// - each function has its own mask pair
// - dma sources default only to dma function
// - relayed errors bridge only; others all functions
// - status bit set on detect regardless of masks
// - severity bit selects uncorrectable or correctable
// - uncorrectable sets flag and signals root complex
// - no new uncorrectable report while flag set
// - correctable sets flag and signals root complex
// - no new correctable report while flag set
// - inject write emulates the matching error
// - injected errors reach bridge function only
// - aged queue packet dropped, type status set
// - memory ecc error sets that memory's bit; only ecc_err[8:0] are logged, ecc_err[13:9] are ignored
// - egress or consumed parity error sets parity bit
`timescale 1ns/1ps
`default_nettype none
`include "pierr_regs.vh"
module pierr_port #(
	parameter NSRC      = `PIERR_NSRC,
	parameter CLK_HZ    = `PIERR_CLK_HZ,
	parameter AGE_LIMIT = `PIERR_TIMEOUT_S * CLK_HZ   // cycles before a queued packet ages out
) (
	input  wire             clk,
	input  wire             resetn,
	input  wire [2:0]       fn_present,           // bridge, nontransparent, dma present
	input  wire             ctl_wr,               // write of int_err_control
	input  wire             ctl_wdata,            // new int_err_report_enable
	output reg              int_err_report_enable,
	input  wire             queue_head_valid,     // packet at head of watched queue
	input  wire [1:0]       queue_head_type,      // 0 posted 1 nonposted 2 completion 3 inserted
	input  wire             queue_head_pop,       // head leaves the queue normally
	output wire             queue_head_discard,   // head dropped for age
	input  wire [13:0]      ecc_err,              // per-memory single/double bit errors
	input  wire             parity_err_egress,    // parity error at egress link layer
	input  wire             parity_err_consumed,  // parity error in consumed packet
	input  wire             dma_parity_err,       // dma data path parity error
	input  wire [2:0]       dma_timeout,          // dma ingress timeouts p, np, cpl
	input  wire [31:0]      relay_err,            // errors relayed from other ports
	input  wire             sts_wr,               // write-one-clear of status pair
	input  wire [NSRC-1:0]  sts_wdata,
	output reg  [NSRC-1:0]  int_err_status_pair,
	input  wire             sev_wr,               // write of severity pair
	input  wire [NSRC-1:0]  sev_wdata,
	output reg  [NSRC-1:0]  int_err_severity_pair,
	input  wire             inject_wr,            // write of inject pair
	input  wire [NSRC-1:0]  inject_wdata,         // ones emulate errors
	input  wire [2:0]       fn_mask_wr,           // per-function mask write
	input  wire [NSRC-1:0]  fn_mask_wdata,
	output wire [NSRC-1:0]  bridge_fn_err_mask,
	output wire [NSRC-1:0]  nontransparent_fn_err_mask,
	output wire [NSRC-1:0]  dma_fn_err_mask,
	input  wire [2:0]       adv_clr_uncorr,       // per-function clear of uncorrectable flag
	input  wire [2:0]       adv_clr_corr,         // per-function clear of correctable flag
	input  wire [2:0]       adv_mask_wr,          // per-function advanced mask write
	input  wire [2:0]       adv_uncorr_mask_in,
	input  wire [2:0]       adv_uncorr_sev_in,
	input  wire [2:0]       adv_corr_mask_in,
	input  wire [2:0]       adv_hlo_mask_in,
	output wire [2:0]       adv_uncorr_status,    // uncorrectable internal flag per function
	output wire [2:0]       adv_corr_status,      // correctable internal flag per function
	output wire [2:0]       adv_uncorr_mask,
	output wire [2:0]       adv_uncorr_severity,
	output wire [2:0]       adv_corr_mask,
	output wire [2:0]       header_log_overflow_mask,
	output wire [2:0]       uncorr_msg,           // one-cycle report per function
	output wire [2:0]       corr_msg,             // one-cycle report per function
	output wire [3*128-1:0] hdr_log               // header log per function
);
	// age counter width covers the limit
	localparam AGE_W = 32;

	reg  [AGE_W-1:0] age_cnt;      // cycles the head has waited
	reg  [NSRC-1:0]  inject_evt;   // one-cycle injected events
	reg  [NSRC-1:0]  hw_evt;       // hardware events this cycle
	wire             age_expired;  // head older than the limit
	wire [NSRC-1:0]  all_evt;      // real plus injected
	wire [NSRC-1:0]  real_evt;     // real events without relayed ones
	wire [2:0]       hdr_valid;    // header log filled per function

	// control bit; reporting enable resets to on
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_err_report_enable <= 1'b1;
		end else if (ctl_wr) begin
			int_err_report_enable <= ctl_wdata;
		end
	end

	// head-of-queue age counter, restarts with each new head
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			age_cnt <= {AGE_W{1'b0}};
		end else if (!queue_head_valid || queue_head_pop || age_expired) begin
			age_cnt <= {AGE_W{1'b0}};
		end else begin
			age_cnt <= age_cnt + 32'h00000001;
		end
	end

	assign age_expired        = queue_head_valid && !queue_head_pop && (age_cnt >= AGE_LIMIT[AGE_W-1:0]);
	assign queue_head_discard = age_expired;

	// gather hardware error sources into their status positions
	always @* begin
		hw_evt = {NSRC{1'b0}};
		if (age_expired) begin
			hw_evt[`PIERR_SRC_TO_POSTED + queue_head_type] = 1'b1;
		end
		hw_evt[`PIERR_SRC_ECC_REPLAY:`PIERR_SRC_ECC_IFB_CTL] = ecc_err[4:0];
		hw_evt[`PIERR_SRC_DMA_EFB_DAT:`PIERR_SRC_DMA_IFB_CTL] = ecc_err[8:5];
		hw_evt[`PIERR_SRC_PARITY]   = parity_err_egress | parity_err_consumed;
		hw_evt[`PIERR_SRC_DMA_PARITY] = dma_parity_err;
		hw_evt[`PIERR_SRC_DMA_TO_CPL:`PIERR_SRC_DMA_TO_P] = dma_timeout;
		hw_evt[NSRC-1:`PIERR_SRC_RELAY_LO] = relay_err;
	end

	// inject writes make one-cycle emulated events
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			inject_evt <= {NSRC{1'b0}};
		end else begin
			inject_evt <= inject_wr ? inject_wdata : {NSRC{1'b0}};
		end
	end

	assign all_evt  = hw_evt | inject_evt;
	assign real_evt = hw_evt & ~`PIERR_RELAY_SRC_MASK;

	// sticky status pair, set independent of masks, set beats clear
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_err_status_pair <= {NSRC{1'b0}};
		end else begin
			int_err_status_pair <= (int_err_status_pair & ~(sts_wr ? sts_wdata : {NSRC{1'b0}}))
			                       | all_evt;
		end
	end

	// severity pair
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			int_err_severity_pair <= `PIERR_SEV_RESET;
		end else if (sev_wr) begin
			int_err_severity_pair <= sev_wdata;
		end
	end

	// bridge sees relayed and injected events; dma defaults hidden
	pierr_fn_aer #(
		.NSRC       (NSRC),
		.MASK_RESET (`PIERR_DMA_SRC_MASK)
	) u_bridge (
		.clk                      (clk),
		.resetn                   (resetn),
		.present                  (fn_present[`PIERR_FN_BRIDGE]),
		.report_enable            (int_err_report_enable),
		.detect                   (all_evt),
		.severity                 (int_err_severity_pair),
		.mask_wr                  (fn_mask_wr[`PIERR_FN_BRIDGE]),
		.mask_wdata               (fn_mask_wdata),
		.clr_uncorr               (adv_clr_uncorr[`PIERR_FN_BRIDGE]),
		.clr_corr                 (adv_clr_corr[`PIERR_FN_BRIDGE]),
		.amask_wr                 (adv_mask_wr[`PIERR_FN_BRIDGE]),
		.amask_uncorr_in          (adv_uncorr_mask_in[`PIERR_FN_BRIDGE]),
		.asev_uncorr_in           (adv_uncorr_sev_in[`PIERR_FN_BRIDGE]),
		.amask_corr_in            (adv_corr_mask_in[`PIERR_FN_BRIDGE]),
		.ahlo_mask_in             (adv_hlo_mask_in[`PIERR_FN_BRIDGE]),
		.fn_err_mask              (bridge_fn_err_mask),
		.uncorr_internal_flag     (adv_uncorr_status[`PIERR_FN_BRIDGE]),
		.corr_internal_flag       (adv_corr_status[`PIERR_FN_BRIDGE]),
		.adv_uncorr_mask          (adv_uncorr_mask[`PIERR_FN_BRIDGE]),
		.adv_uncorr_severity      (adv_uncorr_severity[`PIERR_FN_BRIDGE]),
		.adv_corr_mask            (adv_corr_mask[`PIERR_FN_BRIDGE]),
		.header_log_overflow_mask (header_log_overflow_mask[`PIERR_FN_BRIDGE]),
		.uncorr_msg               (uncorr_msg[`PIERR_FN_BRIDGE]),
		.corr_msg                 (corr_msg[`PIERR_FN_BRIDGE]),
		.hdr_log_valid            (hdr_valid[`PIERR_FN_BRIDGE])
	);

	// nontransparent sees only real local events; dma sources hidden by default
	pierr_fn_aer #(
		.NSRC       (NSRC),
		.MASK_RESET (`PIERR_DMA_SRC_MASK)
	) u_nontransparent (
		.clk                      (clk),
		.resetn                   (resetn),
		.present                  (fn_present[`PIERR_FN_NT]),
		.report_enable            (int_err_report_enable),
		.detect                   (real_evt),
		.severity                 (int_err_severity_pair),
		.mask_wr                  (fn_mask_wr[`PIERR_FN_NT]),
		.mask_wdata               (fn_mask_wdata),
		.clr_uncorr               (adv_clr_uncorr[`PIERR_FN_NT]),
		.clr_corr                 (adv_clr_corr[`PIERR_FN_NT]),
		.amask_wr                 (adv_mask_wr[`PIERR_FN_NT]),
		.amask_uncorr_in          (adv_uncorr_mask_in[`PIERR_FN_NT]),
		.asev_uncorr_in           (adv_uncorr_sev_in[`PIERR_FN_NT]),
		.amask_corr_in            (adv_corr_mask_in[`PIERR_FN_NT]),
		.ahlo_mask_in             (adv_hlo_mask_in[`PIERR_FN_NT]),
		.fn_err_mask              (nontransparent_fn_err_mask),
		.uncorr_internal_flag     (adv_uncorr_status[`PIERR_FN_NT]),
		.corr_internal_flag       (adv_corr_status[`PIERR_FN_NT]),
		.adv_uncorr_mask          (adv_uncorr_mask[`PIERR_FN_NT]),
		.adv_uncorr_severity      (adv_uncorr_severity[`PIERR_FN_NT]),
		.adv_corr_mask            (adv_corr_mask[`PIERR_FN_NT]),
		.header_log_overflow_mask (header_log_overflow_mask[`PIERR_FN_NT]),
		.uncorr_msg               (uncorr_msg[`PIERR_FN_NT]),
		.corr_msg                 (corr_msg[`PIERR_FN_NT]),
		.hdr_log_valid            (hdr_valid[`PIERR_FN_NT])
	);

	// dma sees only real local events, all of them unmasked by default
	pierr_fn_aer #(
		.NSRC       (NSRC),
		.MASK_RESET ({NSRC{1'b0}})
	) u_dma (
		.clk                      (clk),
		.resetn                   (resetn),
		.present                  (fn_present[`PIERR_FN_DMA]),
		.report_enable            (int_err_report_enable),
		.detect                   (real_evt),
		.severity                 (int_err_severity_pair),
		.mask_wr                  (fn_mask_wr[`PIERR_FN_DMA]),
		.mask_wdata               (fn_mask_wdata),
		.clr_uncorr               (adv_clr_uncorr[`PIERR_FN_DMA]),
		.clr_corr                 (adv_clr_corr[`PIERR_FN_DMA]),
		.amask_wr                 (adv_mask_wr[`PIERR_FN_DMA]),
		.amask_uncorr_in          (adv_uncorr_mask_in[`PIERR_FN_DMA]),
		.asev_uncorr_in           (adv_uncorr_sev_in[`PIERR_FN_DMA]),
		.amask_corr_in            (adv_corr_mask_in[`PIERR_FN_DMA]),
		.ahlo_mask_in             (adv_hlo_mask_in[`PIERR_FN_DMA]),
		.fn_err_mask              (dma_fn_err_mask),
		.uncorr_internal_flag     (adv_uncorr_status[`PIERR_FN_DMA]),
		.corr_internal_flag       (adv_corr_status[`PIERR_FN_DMA]),
		.adv_uncorr_mask          (adv_uncorr_mask[`PIERR_FN_DMA]),
		.adv_uncorr_severity      (adv_uncorr_severity[`PIERR_FN_DMA]),
		.adv_corr_mask            (adv_corr_mask[`PIERR_FN_DMA]),
		.header_log_overflow_mask (header_log_overflow_mask[`PIERR_FN_DMA]),
		.uncorr_msg               (uncorr_msg[`PIERR_FN_DMA]),
		.corr_msg                 (corr_msg[`PIERR_FN_DMA]),
		.hdr_log_valid            (hdr_valid[`PIERR_FN_DMA])
	);

	// header log reads all ones once an uncorrectable report is made
	assign hdr_log = {(hdr_valid[2] ? `PIERR_HDR_ONES : 128'h0),
	                  (hdr_valid[1] ? `PIERR_HDR_ONES : 128'h0),
	                  (hdr_valid[0] ? `PIERR_HDR_ONES : 128'h0)};
endmodule // pierr_port
`default_nettype wire

// ==== verif/pierr_port_props.sv ====
// Purpose: concurrent checks on the port internal error reporter
// Assumes: single clock clk, resetn asynchronous active low
// Notes: attached by bind; watches design inputs and outputs
`timescale 1ns/1ps
`default_nettype none
module pierr_port_props #(
	parameter NSRC = 64
) (
	input wire logic            clk,
	input wire logic            resetn,
	input wire logic            int_err_report_enable,
	input wire logic [13:0]     ecc_err,
	input wire logic            parity_err_egress,
	input wire logic            parity_err_consumed,
	input wire logic            inject_wr,
	input wire logic [NSRC-1:0] inject_wdata,
	input wire logic            sts_wr,
	input wire logic [NSRC-1:0] sts_wdata,
	input wire logic [NSRC-1:0] int_err_status_pair,
	input wire logic [2:0]      adv_uncorr_status,
	input wire logic [2:0]      adv_corr_status,
	input wire logic [2:0]      adv_uncorr_mask,
	input wire logic [2:0]      adv_corr_mask,
	input wire logic [2:0]      uncorr_msg,
	input wire logic [2:0]      corr_msg,
	input wire logic [383:0]    hdr_log
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// memory error logs its own bit by the next edge
	a_ecc_logs_bit: assert property (ecc_err[0] |=> int_err_status_pair[4])
		else $error("memory error did not log its status bit");
	// either parity detector logs the path parity bit
	a_parity_logs_bit: assert property ((parity_err_egress || parity_err_consumed) |=> int_err_status_pair[9])
		else $error("parity error did not log its status bit");
	// injected error is logged two edges after the write
	a_inject_logs_late: assert property (inject_wr && inject_wdata[9] |-> ##2 int_err_status_pair[9])
		else $error("injected error not logged");
	// a logged bit only drops through a write of one
	a_status_sticky: assert property ($fell(int_err_status_pair[4]) |-> $past(sts_wr && sts_wdata[4]))
		else $error("status bit dropped without clear");
	// no message while reporting is switched off
	a_enable_gates_msg: assert property (!int_err_report_enable |=> corr_msg == 3'h0 && uncorr_msg == 3'h0)
		else $error("message sent while reporting disabled");
	// advanced fields frozen while reporting is off
	a_fields_frozen: assert property (!int_err_report_enable |=> $stable(adv_uncorr_mask) && $stable(adv_corr_mask)
		&& $stable(adv_uncorr_status) && $stable(adv_corr_status))
		else $error("advanced field changed while disabled");
	// a correctable message always comes with its flag
	a_corr_msg_flag: assert property ((corr_msg & ~adv_corr_status) == 3'h0)
		else $error("correctable message without flag");
	// no second uncorrectable report while the flag stands
	a_uncorr_once: assert property (uncorr_msg[0] |-> !$past(adv_uncorr_status[0]))
		else $error("uncorrectable report repeated");
	// no second correctable report while the flag stands
	a_corr_once: assert property (corr_msg[1] |-> !$past(adv_corr_status[1]))
		else $error("correctable report repeated");
	// uncorrectable report records a header of ones
	a_hdr_all_ones: assert property (uncorr_msg[0] |-> hdr_log[127:0] == {128{1'b1}})
		else $error("header log not all ones");
	c_corr_msg: cover property (corr_msg[0]);
	c_uncorr_msg: cover property (uncorr_msg[0]);
	c_disabled: cover property (!int_err_report_enable);
endmodule // pierr_port_props
bind pierr_port pierr_port_props #(.NSRC(NSRC)) u_props (.clk, .resetn, .int_err_report_enable, .ecc_err,
	.parity_err_egress, .parity_err_consumed, .inject_wr, .inject_wdata, .sts_wr, .sts_wdata,
	.int_err_status_pair, .adv_uncorr_status, .adv_corr_status, .adv_uncorr_mask, .adv_corr_mask,
	.uncorr_msg, .corr_msg, .hdr_log);
`default_nettype wire

// ==== verif/pierr_rc_model.sv ====
// Purpose: root complex side that receives error messages
// Assumes: messages are one-cycle pulses on clk
// Notes: counts per function, 8 bits each, bridge lowest
`timescale 1ns/1ps
`default_nettype none
module pierr_rc_model (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic [2:0]  uncorr_msg,
	input  wire logic [2:0]  corr_msg,
	output var  logic [23:0] corr_cnt,
	output var  logic [23:0] uncorr_cnt
);
	// take each message pulse at the edge it stands
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			corr_cnt <= 24'h000000;
			uncorr_cnt <= 24'h000000;
		end else begin
			for (int i = 0; i < 3; i++) begin
				if (corr_msg[i]) corr_cnt[i*8+:8] <= corr_cnt[i*8+:8] + 8'h01;
				if (uncorr_msg[i]) uncorr_cnt[i*8+:8] <= uncorr_cnt[i*8+:8] + 8'h01;
			end
		end
	end
endmodule // pierr_rc_model
`default_nettype wire

// ==== verif/tb_pierr_port.sv ====
// Purpose: directed test of the port internal error reporter
// Assumes: 50 ns clock, short age limit of 20 cycles
// Notes: strobes set at a rising edge, cleared at the next
`timescale 1ns/1ps
`default_nettype none
`include "pierr_regs.vh"
module tb_pierr_port;
	localparam AGE = 20;   // shortened queue age limit
	logic clk, resetn, ctl_wr, ctl_wdata, queue_head_valid, queue_head_pop, queue_head_discard;
	logic parity_err_egress, parity_err_consumed, dma_parity_err, sts_wr, sev_wr, inject_wr;
	logic int_err_report_enable;
	logic [1:0] queue_head_type;
	logic [2:0] fn_present, dma_timeout, fn_mask_wr, adv_clr_uncorr, adv_clr_corr, adv_mask_wr;
	logic [2:0] adv_uncorr_mask_in, adv_uncorr_sev_in, adv_corr_mask_in, adv_hlo_mask_in;
	logic [2:0] adv_uncorr_status, adv_corr_status, adv_uncorr_mask, adv_uncorr_severity;
	logic [2:0] adv_corr_mask, header_log_overflow_mask, uncorr_msg, corr_msg;
	logic [13:0] ecc_err;
	logic [31:0] relay_err;
	logic [63:0] sts_wdata, sev_wdata, inject_wdata, fn_mask_wdata, int_err_status_pair, int_err_severity_pair;
	logic [63:0] bridge_fn_err_mask, nontransparent_fn_err_mask, dma_fn_err_mask;
	logic [383:0] hdr_log;
	logic [23:0] corr_cnt, uncorr_cnt;   // messages seen by the root complex
	int miscompares, comparisons, n;
	pierr_port #(.AGE_LIMIT(AGE)) dut (.clk, .resetn, .fn_present, .ctl_wr, .ctl_wdata, .int_err_report_enable,
		.queue_head_valid, .queue_head_type, .queue_head_pop, .queue_head_discard, .ecc_err, .parity_err_egress,
		.parity_err_consumed, .dma_parity_err, .dma_timeout, .relay_err, .sts_wr, .sts_wdata, .int_err_status_pair,
		.sev_wr, .sev_wdata, .int_err_severity_pair, .inject_wr, .inject_wdata, .fn_mask_wr, .fn_mask_wdata,
		.bridge_fn_err_mask, .nontransparent_fn_err_mask, .dma_fn_err_mask, .adv_clr_uncorr, .adv_clr_corr,
		.adv_mask_wr, .adv_uncorr_mask_in, .adv_uncorr_sev_in, .adv_corr_mask_in, .adv_hlo_mask_in,
		.adv_uncorr_status, .adv_corr_status, .adv_uncorr_mask, .adv_uncorr_severity, .adv_corr_mask,
		.header_log_overflow_mask, .uncorr_msg, .corr_msg, .hdr_log);
	pierr_rc_model rc (.clk, .resetn, .uncorr_msg, .corr_msg, .corr_cnt, .uncorr_cnt);
	// free-running 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// compare and count
	task chk(input logic [127:0] got, input logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// drop every strobe, then let the results and messages land
	task go;
		@(posedge clk);
		{ctl_wr, sts_wr, sev_wr, inject_wr, parity_err_consumed} <= 5'h00;
		{ecc_err, dma_timeout, fn_mask_wr, adv_clr_corr, adv_clr_uncorr, adv_mask_wr, relay_err} <= 0;
		@(posedge clk);
		#1;
	endtask
	// clear correctable flags of all functions
	task clrc;
		@(posedge clk);
		adv_clr_corr <= 3'h7;
		go;
	endtask
	// verdict and end of run
	task test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{resetn, ctl_wr, ctl_wdata, queue_head_valid, queue_head_pop, parity_err_egress} = 6'h00;
		{parity_err_consumed, dma_parity_err, sts_wr, sev_wr, inject_wr, queue_head_type} = 7'h00;
		{dma_timeout, fn_mask_wr, adv_clr_uncorr, adv_clr_corr, adv_mask_wr} = 15'h0000;
		{adv_uncorr_mask_in, adv_uncorr_sev_in, adv_corr_mask_in, adv_hlo_mask_in} = 12'hFFF;
		{ecc_err, relay_err, sts_wdata, sev_wdata, inject_wdata, fn_mask_wdata} = 0;
		fn_present = 3'h7;
		miscompares = 0;
		comparisons = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		#1;
		chk(int_err_report_enable, 1'b1);
		chk(bridge_fn_err_mask, `PIERR_DMA_SRC_MASK);
		chk(nontransparent_fn_err_mask, `PIERR_DMA_SRC_MASK);
		chk(dma_fn_err_mask, 64'h0000000000000000);
		chk(int_err_severity_pair, `PIERR_SEV_RESET);
		// memory error goes to every function, then repeats are held back
		@(posedge clk); ecc_err <= 14'h0001; go;
		chk(int_err_status_pair[4], 1'b1);
		chk(adv_corr_status, 3'h7);
		chk(corr_cnt, 24'h010101);
		@(posedge clk); ecc_err <= 14'h0002; go;
		chk(int_err_status_pair[5], 1'b1);
		chk(corr_cnt, 24'h010101);
		// dma source reaches the dma function only
		clrc;
		@(posedge clk); dma_timeout <= 3'h1; go;
		chk({int_err_status_pair[10], adv_corr_status}, 4'hC);
		// relayed error reaches the bridge only
		clrc;
		@(posedge clk); relay_err <= 32'h00000001; go;
		chk({int_err_status_pair[32], adv_corr_status}, 4'h9);
		// bridge mask hides one memory from the bridge alone
		clrc;
		@(posedge clk); fn_mask_wr <= 3'h1; fn_mask_wdata <= `PIERR_DMA_SRC_MASK | 64'h40; go;
		@(posedge clk); ecc_err <= 14'h0004; go;
		chk({int_err_status_pair[6], adv_corr_status}, 4'hE);
		chk(corr_cnt, 24'h030202);
		// injected uncorrectable error, bridge only, header of ones
		@(posedge clk); sev_wr <= 1'b1; sev_wdata <= 64'h200; go;
		chk(int_err_severity_pair, 64'h200);
		@(posedge clk); inject_wr <= 1'b1; inject_wdata <= 64'h200; go; go;
		chk({int_err_status_pair[9], adv_uncorr_status}, 4'h9);
		chk(uncorr_cnt, 24'h000001);
		chk(hdr_log[127:0], `PIERR_HDR_ONES);
		chk(hdr_log[255:128], 128'h0);
		// write-one clear leaves other bits, then a consumed parity error
		@(posedge clk); sts_wr <= 1'b1; sts_wdata <= 64'h210; go;
		chk(int_err_status_pair[9:4], 6'h06);
		@(posedge clk); parity_err_consumed <= 1'b1; go;
		chk(int_err_status_pair[9], 1'b1);
		chk(uncorr_cnt, 24'h010101);
		// reporting switched off: fields frozen, logging goes on
		clrc;
		@(posedge clk); ctl_wr <= 1'b1; ctl_wdata <= 1'b0; go;
		@(posedge clk); adv_mask_wr <= 3'h7; adv_clr_uncorr <= 3'h7; go;
		chk({header_log_overflow_mask, adv_uncorr_severity, adv_corr_mask, adv_uncorr_mask, adv_uncorr_status}, 15'h0007);
		@(posedge clk); ecc_err <= 14'h0008; go;
		chk({int_err_status_pair[7], adv_corr_status}, 4'h8);
		chk(corr_cnt, 24'h030202);
		@(posedge clk); ctl_wr <= 1'b1; ctl_wdata <= 1'b1; go;
		// packet aging at the head of a queue
		@(posedge clk); queue_head_valid <= 1'b1; queue_head_type <= 2'h2;
		for (n = 0; n < 40; n++) begin
			@(posedge clk);
			#1;
			if (queue_head_discard === 1'b1) break;
		end
		if (n == 40) begin
			miscompares++;
			test_done;
		end
		chk(n, AGE - 1);
		@(posedge clk); queue_head_valid <= 1'b0; go;
		chk(int_err_status_pair[2], 1'b1);
		test_done;
	end
endmodule // tb_pierr_port
`default_nettype wire
